// ==== src/ubi_params.svh ====
// offsets, field positions, sticky mask of the bridge interrupt logic
`ifndef UBI_PARAMS_SVH
`define UBI_PARAMS_SVH
`define UBI_OFS_STATUS 12'h000
`define UBI_OFS_ENABLE 12'h004
`define UBI_OFS_SWRST 12'h020
`define UBI_ADDR_MSB 11
`define UBI_ADDR_LSB 2
`define UBI_BIT_EP_RERR 29
`define UBI_BIT_DMA_RD 25
`define UBI_BIT_CORE_RD 24
`define UBI_BIT_MR_BUSERR 23
`define UBI_BIT_MR_FIFO 22
`define UBI_BIT_MR_DONE 21
`define UBI_BIT_MW_BUSERR 20
`define UBI_BIT_MW_TOUT 19
`define UBI_BIT_MW_DONE 18
`define UBI_BIT_MW_ADDR 17
`define UBI_BIT_BRST_END 10
`define UBI_BIT_BRST 9
`define UBI_BIT_SUSP 8
`define UBI_STICKY_MASK 32'h23fe0700
`define UBI_ZERO32 32'h00000000
`define UBI_MIRROR_W 8
`endif

// ==== src/ubi_pkg.sv ====
// types of the bridge interrupt logic
package ubi_pkg;
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] enable;
    logic core_brst_q;
    logic core_susp_q;
    logic mr_fifo_full_q;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ubi_state_t;
endpackage

// ==== src/ubi_irq_logic.sv ====
// interrupt status and enable registers of the usb bridge
// ----------------------------------------------------------------
// How it works
// - write path common-bus endpoint access sets error
// - dma register read done sets flag
// - core register read or write done
// - read path bus error sets flag
// - read fifo leaving full sets flag
// - read path transfer end sets flag
// - write path bus error sets flag
// - write path timeout sets flag
// - write path transfer end sets flag
// - rx data while write disabled sets flag
// - core bus reset falling sets flag
// - core bus reset rising sets flag
// - any suspend indicator change sets flag
// - low eight bits mirror core flags
// - enable bits gate sources onto irq
// - status latches regardless of enable
// - no enables for mirrored low bits
// - enable bits writable, reset zero, rest reserved
// - write one clears sticky status bits
// - enables survive software reset
// ----------------------------------------------------------------
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "ubi_params.svh"
module ubi_irq_logic
  import ubi_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // register bus slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // transfer path events, one-cycle pulses except read fifo full, a level
  input wire logic i_mw_ep_common_access,
  input wire logic i_dma_reg_rd_done,
  input wire logic i_core_reg_rd_done,
  input wire logic i_core_reg_wr_done,
  input wire logic i_mr_bus_error,
  input wire logic i_mr_fifo_full,
  input wire logic i_mr_done,
  input wire logic i_mw_bus_error,
  input wire logic i_mw_timeout,
  input wire logic i_mw_done,
  input wire logic i_mw_rx_data_while_off,
  // core levels
  input wire logic i_core_bus_reset,
  input wire logic i_core_suspend,
  input wire logic [7:0] i_core_irq_flags,
  input wire logic i_soft_reset,
  // interrupt
  output logic o_combined_irq
);
  ubi_state_t st;
  ubi_state_t next_st;
  logic [31:0] evt;
  logic acc;
  logic wr_en;
  logic wr_st;
  logic wr_swr;
  logic [31:0] next_status_lo;
  logic [31:0] clr_req;
  logic srst_req;
  logic [31:0] irq_hits;

  function automatic logic is_reg(input logic [31:0] a, input logic [11:0] ofs);
    is_reg = (a[`UBI_ADDR_MSB:`UBI_ADDR_LSB] == ofs[`UBI_ADDR_MSB:`UBI_ADDR_LSB]);
  endfunction

  // set beats a same-cycle clear, so an event that races a
  // write-one-clear or a soft reset is never lost
  function automatic logic sticky_next(
    input logic held,
    input logic hit,
    input logic clr,
    input logic srst
  );
    logic kept;
    kept = held && !clr && !srst;
    sticky_next = kept || hit;
  endfunction

  // a plain read/write bit, left alone by both soft reset paths
  function automatic logic enable_next(
    input logic held,
    input logic wr,
    input logic d
  );
    enable_next = wr ? d : held;
  endfunction

  always_comb begin
    next_st = st;
    evt = `UBI_ZERO32;
    next_status_lo = `UBI_ZERO32;
    acc = i_psel && i_penable && !st.pready;
    wr_en = acc && i_pwrite && is_reg(i_paddr, `UBI_OFS_ENABLE);
    wr_st = acc && i_pwrite && is_reg(i_paddr, `UBI_OFS_STATUS);
    wr_swr = acc && i_pwrite && is_reg(i_paddr, `UBI_OFS_SWRST);
    // -------------------------------------------------------------
    // event capture
    // -------------------------------------------------------------
    // level inputs are compared with last cycle's copy to find edges
    evt[`UBI_BIT_EP_RERR] = i_mw_ep_common_access;
    evt[`UBI_BIT_DMA_RD] = i_dma_reg_rd_done;
    evt[`UBI_BIT_CORE_RD] = i_core_reg_rd_done || i_core_reg_wr_done;
    evt[`UBI_BIT_MR_BUSERR] = i_mr_bus_error;
    evt[`UBI_BIT_MR_FIFO] = st.mr_fifo_full_q && !i_mr_fifo_full;
    evt[`UBI_BIT_MR_DONE] = i_mr_done;
    evt[`UBI_BIT_MW_BUSERR] = i_mw_bus_error;
    evt[`UBI_BIT_MW_TOUT] = i_mw_timeout;
    evt[`UBI_BIT_MW_DONE] = i_mw_done;
    evt[`UBI_BIT_MW_ADDR] = i_mw_rx_data_while_off;
    evt[`UBI_BIT_BRST_END] = st.core_brst_q && !i_core_bus_reset;
    evt[`UBI_BIT_BRST] = !st.core_brst_q && i_core_bus_reset;
    evt[`UBI_BIT_SUSP] = st.core_susp_q ^ i_core_suspend;
    next_st.core_brst_q = i_core_bus_reset;
    next_st.core_susp_q = i_core_suspend;
    next_st.mr_fifo_full_q = i_mr_fifo_full;
    // -------------------------------------------------------------
    // status: set wins over write-one clear and over soft reset
    // -------------------------------------------------------------
    // a write-one-clear only reaches the sticky positions
    clr_req = `UBI_ZERO32;
    if (wr_st) begin
      clr_req = i_pwdata & `UBI_STICKY_MASK;
    end
    // software reset by pin or by register write, enables untouched
    srst_req = i_soft_reset || (wr_swr && i_pwdata[0]);

    next_status_lo[`UBI_BIT_EP_RERR] = sticky_next(
      st.status[`UBI_BIT_EP_RERR],
      evt[`UBI_BIT_EP_RERR],
      clr_req[`UBI_BIT_EP_RERR],
      srst_req
    );

    next_status_lo[`UBI_BIT_DMA_RD] = sticky_next(
      st.status[`UBI_BIT_DMA_RD],
      evt[`UBI_BIT_DMA_RD],
      clr_req[`UBI_BIT_DMA_RD],
      srst_req
    );

    next_status_lo[`UBI_BIT_CORE_RD] = sticky_next(
      st.status[`UBI_BIT_CORE_RD],
      evt[`UBI_BIT_CORE_RD],
      clr_req[`UBI_BIT_CORE_RD],
      srst_req
    );

    next_status_lo[`UBI_BIT_MR_BUSERR] = sticky_next(
      st.status[`UBI_BIT_MR_BUSERR],
      evt[`UBI_BIT_MR_BUSERR],
      clr_req[`UBI_BIT_MR_BUSERR],
      srst_req
    );

    next_status_lo[`UBI_BIT_MR_FIFO] = sticky_next(
      st.status[`UBI_BIT_MR_FIFO],
      evt[`UBI_BIT_MR_FIFO],
      clr_req[`UBI_BIT_MR_FIFO],
      srst_req
    );

    next_status_lo[`UBI_BIT_MR_DONE] = sticky_next(
      st.status[`UBI_BIT_MR_DONE],
      evt[`UBI_BIT_MR_DONE],
      clr_req[`UBI_BIT_MR_DONE],
      srst_req
    );

    next_status_lo[`UBI_BIT_MW_BUSERR] = sticky_next(
      st.status[`UBI_BIT_MW_BUSERR],
      evt[`UBI_BIT_MW_BUSERR],
      clr_req[`UBI_BIT_MW_BUSERR],
      srst_req
    );

    next_status_lo[`UBI_BIT_MW_TOUT] = sticky_next(
      st.status[`UBI_BIT_MW_TOUT],
      evt[`UBI_BIT_MW_TOUT],
      clr_req[`UBI_BIT_MW_TOUT],
      srst_req
    );

    next_status_lo[`UBI_BIT_MW_DONE] = sticky_next(
      st.status[`UBI_BIT_MW_DONE],
      evt[`UBI_BIT_MW_DONE],
      clr_req[`UBI_BIT_MW_DONE],
      srst_req
    );

    next_status_lo[`UBI_BIT_MW_ADDR] = sticky_next(
      st.status[`UBI_BIT_MW_ADDR],
      evt[`UBI_BIT_MW_ADDR],
      clr_req[`UBI_BIT_MW_ADDR],
      srst_req
    );

    next_status_lo[`UBI_BIT_BRST_END] = sticky_next(
      st.status[`UBI_BIT_BRST_END],
      evt[`UBI_BIT_BRST_END],
      clr_req[`UBI_BIT_BRST_END],
      srst_req
    );

    next_status_lo[`UBI_BIT_BRST] = sticky_next(
      st.status[`UBI_BIT_BRST],
      evt[`UBI_BIT_BRST],
      clr_req[`UBI_BIT_BRST],
      srst_req
    );

    next_status_lo[`UBI_BIT_SUSP] = sticky_next(
      st.status[`UBI_BIT_SUSP],
      evt[`UBI_BIT_SUSP],
      clr_req[`UBI_BIT_SUSP],
      srst_req
    );

    // latched whatever the enable says
    next_st.status = next_status_lo;
    // mirror bits are live copies, never stored as sticky
    next_st.status[`UBI_MIRROR_W-1:0] = i_core_irq_flags;
    // -------------------------------------------------------------
    // enable register, untouched by soft reset
    // -------------------------------------------------------------
    // reserved and mirror positions have no storage; they read 0
    next_st.enable[`UBI_BIT_EP_RERR] = enable_next(
      st.enable[`UBI_BIT_EP_RERR],
      wr_en,
      i_pwdata[`UBI_BIT_EP_RERR]
    );

    next_st.enable[`UBI_BIT_DMA_RD] = enable_next(
      st.enable[`UBI_BIT_DMA_RD],
      wr_en,
      i_pwdata[`UBI_BIT_DMA_RD]
    );

    next_st.enable[`UBI_BIT_CORE_RD] = enable_next(
      st.enable[`UBI_BIT_CORE_RD],
      wr_en,
      i_pwdata[`UBI_BIT_CORE_RD]
    );

    next_st.enable[`UBI_BIT_MR_BUSERR] = enable_next(
      st.enable[`UBI_BIT_MR_BUSERR],
      wr_en,
      i_pwdata[`UBI_BIT_MR_BUSERR]
    );

    next_st.enable[`UBI_BIT_MR_FIFO] = enable_next(
      st.enable[`UBI_BIT_MR_FIFO],
      wr_en,
      i_pwdata[`UBI_BIT_MR_FIFO]
    );

    next_st.enable[`UBI_BIT_MR_DONE] = enable_next(
      st.enable[`UBI_BIT_MR_DONE],
      wr_en,
      i_pwdata[`UBI_BIT_MR_DONE]
    );

    next_st.enable[`UBI_BIT_MW_BUSERR] = enable_next(
      st.enable[`UBI_BIT_MW_BUSERR],
      wr_en,
      i_pwdata[`UBI_BIT_MW_BUSERR]
    );

    next_st.enable[`UBI_BIT_MW_TOUT] = enable_next(
      st.enable[`UBI_BIT_MW_TOUT],
      wr_en,
      i_pwdata[`UBI_BIT_MW_TOUT]
    );

    next_st.enable[`UBI_BIT_MW_DONE] = enable_next(
      st.enable[`UBI_BIT_MW_DONE],
      wr_en,
      i_pwdata[`UBI_BIT_MW_DONE]
    );

    next_st.enable[`UBI_BIT_MW_ADDR] = enable_next(
      st.enable[`UBI_BIT_MW_ADDR],
      wr_en,
      i_pwdata[`UBI_BIT_MW_ADDR]
    );

    next_st.enable[`UBI_BIT_BRST_END] = enable_next(
      st.enable[`UBI_BIT_BRST_END],
      wr_en,
      i_pwdata[`UBI_BIT_BRST_END]
    );

    next_st.enable[`UBI_BIT_BRST] = enable_next(
      st.enable[`UBI_BIT_BRST],
      wr_en,
      i_pwdata[`UBI_BIT_BRST]
    );

    next_st.enable[`UBI_BIT_SUSP] = enable_next(
      st.enable[`UBI_BIT_SUSP],
      wr_en,
      i_pwdata[`UBI_BIT_SUSP]
    );

    // -------------------------------------------------------------
    // combined interrupt, one cycle behind status
    // -------------------------------------------------------------
    // each source gated by its own enable; unused positions stay zero
    irq_hits = `UBI_ZERO32;
    irq_hits[`UBI_BIT_EP_RERR] = st.status[`UBI_BIT_EP_RERR] && st.enable[`UBI_BIT_EP_RERR];
    irq_hits[`UBI_BIT_DMA_RD] = st.status[`UBI_BIT_DMA_RD] && st.enable[`UBI_BIT_DMA_RD];
    irq_hits[`UBI_BIT_CORE_RD] = st.status[`UBI_BIT_CORE_RD] && st.enable[`UBI_BIT_CORE_RD];
    irq_hits[`UBI_BIT_MR_BUSERR] = st.status[`UBI_BIT_MR_BUSERR] && st.enable[`UBI_BIT_MR_BUSERR];
    irq_hits[`UBI_BIT_MR_FIFO] = st.status[`UBI_BIT_MR_FIFO] && st.enable[`UBI_BIT_MR_FIFO];
    irq_hits[`UBI_BIT_MR_DONE] = st.status[`UBI_BIT_MR_DONE] && st.enable[`UBI_BIT_MR_DONE];
    irq_hits[`UBI_BIT_MW_BUSERR] = st.status[`UBI_BIT_MW_BUSERR] && st.enable[`UBI_BIT_MW_BUSERR];
    irq_hits[`UBI_BIT_MW_TOUT] = st.status[`UBI_BIT_MW_TOUT] && st.enable[`UBI_BIT_MW_TOUT];
    irq_hits[`UBI_BIT_MW_DONE] = st.status[`UBI_BIT_MW_DONE] && st.enable[`UBI_BIT_MW_DONE];
    irq_hits[`UBI_BIT_MW_ADDR] = st.status[`UBI_BIT_MW_ADDR] && st.enable[`UBI_BIT_MW_ADDR];
    irq_hits[`UBI_BIT_BRST_END] = st.status[`UBI_BIT_BRST_END] && st.enable[`UBI_BIT_BRST_END];
    irq_hits[`UBI_BIT_BRST] = st.status[`UBI_BIT_BRST] && st.enable[`UBI_BIT_BRST];
    irq_hits[`UBI_BIT_SUSP] = st.status[`UBI_BIT_SUSP] && st.enable[`UBI_BIT_SUSP];
    // mirrored flags are enabled inside the core, so they pass ungated
    next_st.irq = |irq_hits || |st.status[`UBI_MIRROR_W-1:0];
    // -------------------------------------------------------------
    // bus answer: one wait state, unmapped reads zero with error
    // -------------------------------------------------------------
    next_st.pready = acc;
    next_st.pslverr = 1'b0;
    next_st.prdata = `UBI_ZERO32;
    if (acc && !i_pwrite) begin
      if (is_reg(i_paddr, `UBI_OFS_STATUS)) begin
        next_st.prdata = st.status;
      end else if (is_reg(i_paddr, `UBI_OFS_ENABLE)) begin
        next_st.prdata = st.enable;
      end else if (is_reg(i_paddr, `UBI_OFS_SWRST)) begin
        next_st.prdata = `UBI_ZERO32;
      end else begin
        next_st.pslverr = 1'b1;
      end
    end else if (acc) begin
      next_st.pslverr = !(wr_en || wr_st || wr_swr);
    end
  end

  // one register stage for all state; a low clock enable holds every
  // bit, the bus answer included, so a stalled master sees no pulse
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_combined_irq = st.irq;
endmodule

// ==== tb/ubi_checker.sv ====
// port assertions of the bridge interrupt logic
`timescale 1ns/1ns
module ubi_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic [7:0] i_core_irq_flags,
  input wire logic o_combined_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  wait_one_a: assert property (i_psel && !i_penable ##1 i_penable |=> o_pready)
    else $error("ready late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  ready_cause_a: assert property (o_pready |-> $past(i_penable))
    else $error("ready without access");
  refused_zero_a: assert property (o_pslverr |-> o_pready && o_prdata == 0)
    else $error("bad refusal");
  idle_data_a: assert property (!o_pready |-> o_prdata == 0)
    else $error("data outside answer");
  reserved_zero_a: assert property (o_pready |-> (o_prdata & 32'hdc01f800) == 0)
    else $error("reserved bit set");
  mirror_irq_a: assert property ($past(i_core_irq_flags, 2) != 0 |-> o_combined_irq)
    else $error("mirror not on irq");
  reset_quiet_a: assert property ($rose(i_rst_b) |-> !o_combined_irq && !o_pready)
    else $error("output after reset");
  cover property (o_pslverr);
  cover property (o_combined_irq);
  cover property (o_pready && o_prdata[29]);
endmodule
bind ubi_irq_logic ubi_checker ubi_checker_inst (.i_clk_sys, .i_rst_b, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .o_prdata, .i_core_irq_flags, .o_combined_irq);

// ==== tb/ubi_partner.sv ====
// far-side model: transfer path events and core flag outputs
`timescale 1ns/1ns
module ubi_partner (
  input wire logic i_clk_sys,
  input wire logic [12:0] i_cmd,
  input wire logic [7:0] i_flags,
  output logic [12:0] o_ev,
  output logic [7:0] o_flags
);
  // launched from a clock edge, as the real engines would
  always_ff @(posedge i_clk_sys) begin
    o_ev <= i_cmd;
    o_flags <= i_flags;
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the bridge interrupt logic
`timescale 1ns/1ns
module testbench;
  logic i_clk_sys = 0, i_rst_b = 0, i_clk_en = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_soft_reset = 0, o_pready, o_pslverr, o_combined_irq, er;
  logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, rd;
  logic [12:0] cmd = 0, ev;
  logic [7:0] flg = 0, fl;
  int mismatches = 0, check_count = 0, cyc = 0, m_en = 0, m_sts = 0;
  int pos[13] = '{29, 25, 24, 24, 23, 22, 21, 20, 19, 18, 17, 9, 8};
  ubi_partner ubi_partner_inst (.i_clk_sys, .i_cmd(cmd), .i_flags(flg), .o_ev(ev), .o_flags(fl));
  ubi_irq_logic ubi_irq_logic_inst (.*, .i_mw_ep_common_access(ev[0]), .i_dma_reg_rd_done(ev[1]),
    .i_core_reg_rd_done(ev[2]), .i_core_reg_wr_done(ev[3]), .i_mr_bus_error(ev[4]),
    .i_mr_fifo_full(ev[5]), .i_mr_done(ev[6]), .i_mw_bus_error(ev[7]), .i_mw_timeout(ev[8]),
    .i_mw_done(ev[9]), .i_mw_rx_data_while_off(ev[10]), .i_core_bus_reset(ev[11]),
    .i_core_suspend(ev[12]), .i_core_irq_flags(fl));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // holds the request until pready is seen, then releases
  task automatic bus_xfer(input logic w, input logic [31:0] a, d);
    @(posedge i_clk_sys);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_clk_sys);
    i_penable <= 1;
    do @(posedge i_clk_sys); while (o_pready !== 1 && cyc < 3000);
    {rd, er} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    if (++cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'hf4749fda));
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1;
    bus_xfer(0, 0, 0);
    chk("status", m_sts, rd);
    bus_xfer(0, 4, 0);
    chk("enable", m_en, rd);
    bus_xfer(0, 8, 0);
    chk("slverr", 1, er);
    bus_xfer(1, 4, '1);
    m_en = 32'h23fe0700;
    bus_xfer(0, 4, 0);
    chk("enable mask", m_en, rd);
    $display("registers done");
    bus_xfer(1, 4, 0);
    m_en = 0;
    foreach (pos[i]) begin
      @(posedge i_clk_sys) cmd[i] <= 1;
      @(posedge i_clk_sys) cmd[i] <= 0;
      m_sts = (1 << pos[i]) | (i == 11 ? 32'h400 : 0);
      bus_xfer(0, 0, 0);
      chk("event", m_sts, rd);
      chk("irq held", |(m_en & m_sts), o_combined_irq);
      bus_xfer(1, 4, m_sts);
      m_en = m_sts;
      @(posedge i_clk_sys);
      chk("irq enabled", 1, o_combined_irq);
      bus_xfer(1, 0, m_sts);
      m_sts = 0;
      bus_xfer(0, 0, 0);
      chk("w1c", m_sts, rd);
      chk("irq cleared", 0, o_combined_irq);
    end
    $display("events done");
    flg <= 8'($urandom) | 8'h01;
    bus_xfer(1, 0, '1);
    bus_xfer(0, 0, 0);
    chk("mirror", {24'h0, flg}, rd);
    chk("mirror irq", 1, o_combined_irq);
    flg <= 0;
    $display("mirror done");
    @(posedge i_clk_sys) cmd[12] <= 1;
    @(posedge i_clk_sys) cmd[12] <= 0;
    repeat (2) @(posedge i_clk_sys);
    i_soft_reset <= 1;
    @(posedge i_clk_sys) i_soft_reset <= 0;
    bus_xfer(0, 0, 0);
    chk("soft status", 0, rd);
    bus_xfer(0, 4, 0);
    chk("soft enable", m_en, rd);
    $display("soft reset done");
    @(posedge i_clk_sys) cmd[4] <= 1;
    @(posedge i_clk_sys) cmd[4] <= 0;
    bus_xfer(1, 32'h20, 1);
    bus_xfer(0, 0, 0);
    chk("soft register", 0, rd);
    bus_xfer(0, 4, 0);
    chk("enable kept", m_en, rd);
    @(posedge i_clk_sys) cmd[7] <= 1;
    @(posedge i_clk_sys) cmd[7] <= 0;
    bus_xfer(1, 0, 32'h00100000);
    bus_xfer(1, 4, 32'h00100000);
    m_en = 32'h00100000;
    @(posedge i_clk_sys);
    chk("clear first", 0, o_combined_irq);
    $display("ordering done");
    report_and_stop;
  end
endmodule
